// ### hw/rct_pkg.sv
// Purpose: Shared constants and types for the reset-cause and time-out block
// Assumes: 100 MHz core clock, one aligned register per plain-port address
// Notes:   Every offset, field position, reset value and cycle count lives here
package rct_pkg;

  // ******************************************************
  // Timing
  // ******************************************************
  localparam int CLK_PERIOD_NS = 10;               // Core clock period
  localparam int POWERUP_TIMER_TIME_MS = 64;                // Power-up timer, nominal
  localparam int POWERUP_TIMER_CYCLES = POWERUP_TIMER_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int OST_OSC_PERIODS = 1024;           // Oscillator start-up count
  localparam int INTERNAL_OSCILLATOR_MODE_TIME_NS = 1000;            // Short internal time-out
  localparam int INTERNAL_OSCILLATOR_MODE_CYCLES =
    (INTERNAL_OSCILLATOR_MODE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 24;                       // Delay counter width
  localparam int PC_W = 15;                        // Program counter width

  // ******************************************************
  // Register offsets
  // ******************************************************
  localparam int ADDR_W = 3;
  localparam logic [2:0] OFS_PWR_CTRL = 3'h0;      // Power-control flags
  localparam logic [2:0] OFS_CORE_STAT = 3'h1;     // Time-out / power-down
  localparam logic [2:0] OFS_IRQ_STAT = 3'h2;      // Sticky event bits
  localparam logic [2:0] OFS_IRQ_MASK = 3'h3;      // Event mask

  // ******************************************************
  // Field positions
  // ******************************************************
  localparam int PCB_STK_OVER = 7;
  localparam int PCB_STK_UNDER = 6;
  localparam int PCB_PIN = 3;
  localparam int PCB_SWRST = 2;
  localparam int PCB_POR = 1;
  localparam int PCB_BOR = 0;
  localparam int STB_TIMEOUT = 4;
  localparam int STB_POWERDOWN = 3;
  localparam int IRQ_W = 6;
  localparam int IRB_READY = 0;                    // Start-up finished
  localparam int IRB_STACK = 1;                    // Stack fault seen
  localparam int IRB_PIN = 2;                      // Pin reset
  localparam int IRB_SWRST = 3;                    // Reset instruction
  localparam int IRB_WDT = 4;                      // Watchdog reset or wake
  localparam int IRB_BOR = 5;                      // Brown-out reset

  // ******************************************************
  // Reset values and vectors
  // ******************************************************
  localparam logic [7:0] POWER_CONTROL_REG_POR_VAL = 8'h0C;     // 00 110x, x taken as 0
  localparam logic [7:0] POWER_CONTROL_REG_WR_MASK = 8'hCF;     // Bits 5:4 unimplemented
  localparam logic [2:0] SYNC_RST_VAL = 3'h3;      // Power sources held
  localparam logic [PC_W-1:0] PC_RESET_VEC = 15'h0000;
  localparam logic [PC_W-1:0] PC_IRQ_VEC = 15'h0004;

  // ******************************************************
  // Enumerations
  // ******************************************************
  typedef enum logic [2:0] {
    OSC_CRYSTAL_MODE_LOW = 3'b000,
    OSC_CRYSTAL_MODE_MID = 3'b001,
    OSC_CRYSTAL_MODE_HIGH = 3'b010,
    OSC_RC_MODE = 3'b011,
    OSC_EXTERNAL_CLOCK_MODE = 3'b100,
    OSC_INTERNAL_OSCILLATOR_MODE = 3'b101
  } rct_osc_e;

  typedef enum logic [2:0] {
    ST_HOLD = 3'b000,                              // Power source active
    ST_POWERUP_TIMER = 3'b001,                              // Power-up timer
    ST_OST = 3'b010,                               // Oscillator start-up
    ST_SHORT = 3'b011,                             // Short internal time-out
    ST_PIN = 3'b100,                               // Wait for pin release
    ST_RUN = 3'b101,                               // Core executing
    ST_WAKE = 3'b110                               // Wake-up time-out
  } rct_seq_e;

endpackage : rct_pkg

// ### hw/rct_delay_tmr.sv
// Purpose: Loadable down-counter giving a one-cycle done pulse
// Assumes: Count loaded is at least one; a new load restarts the count
// Notes:   Clock enable low freezes the count
`timescale 1ns/100ps
`default_nettype none
module rct_delay_tmr
  import rct_pkg::*;
#(
  parameter int W = TMR_W
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  // Control
  input wire logic load_i,
  input wire logic [W-1:0] count_i,
  // Status
  output logic done_o
);

  // ******************************************************
  // State
  // ******************************************************
  typedef struct packed {
    logic [W-1:0] cnt;                             // Cycles remaining
    logic busy;                                    // Counting
    logic done;                                    // Expiry pulse
  } rct_tmr_s;

  rct_tmr_s tmr_ff;
  rct_tmr_s nxt_tmr;

  // Next-state logic
  always_comb begin
    nxt_tmr = tmr_ff;
    nxt_tmr.done = 1'b0;
    if (load_i) begin
      // Restart on every load
      nxt_tmr.cnt = count_i;
      nxt_tmr.busy = 1'b1;
    end else if (tmr_ff.busy) begin
      nxt_tmr.cnt = tmr_ff.cnt - 1'b1;
      if (tmr_ff.cnt <= W'(1)) begin
        // Last cycle of the delay
        nxt_tmr.busy = 1'b0;
        nxt_tmr.done = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tmr_ff <= '0;
    end else if (clk_en_i) begin
      tmr_ff <= nxt_tmr;
    end
  end

  assign done_o = tmr_ff.done;

endmodule : rct_delay_tmr
`default_nettype wire

// ### hw/rct_top.sv
// Purpose: Reset-cause recording and power-up time-out sequencing
// Assumes: Power, brown-out and pin requests are asynchronous levels
// Notes:   Core reset, flags and program counter load come from flip-flops
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Reset instruction resets, clears its flag
// - Stack fault with enable: flag and reset in the same cycle
// - Stack fault without enable: flag only
// - Stack flags stay until software, power-on or brown-out
// - Power-up timer after power release, then oscillator
// - External clock, timer disabled: no time-out
// - Time-outs ignore pin; late pin starts immediately
// - Time-out lengths chosen by oscillator mode
// - Pin reset clears its flag
// - Power-on clears power-on bit; software re-arms
// - Brown-out clears its bit; software re-arms
// - Flag loads per reset type
// - Resets load 0000h; wakes continue, vector 0004h
// - Time-out and power-down bits per event
// - Power-control bits 5 and 4 read zero
module rct_top
  import rct_pkg::*;
#(
  parameter int POWERUP_TIMER_CYC = POWERUP_TIMER_CYCLES,            // Power-up timer cycles
  parameter int CLK_PER_OSC = 1,                   // Core clocks per osc period
  parameter int OST_CYC = OST_OSC_PERIODS * CLK_PER_OSC
) (
  // Clock, reset, enable
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  // Asynchronous reset sources
  input wire logic power_on_req_i,
  input wire logic brown_out_reset_i,
  input wire logic master_clear_pin_n_i,
  // Core events
  input wire logic sw_reset_instr_i,
  input wire logic stack_over_i,
  input wire logic stack_under_i,
  input wire logic wdt_timeout_i,
  input wire logic wake_irq_i,
  input wire logic sleep_i,
  input wire logic global_irq_enable_i,
  input wire logic instr_done_i,
  input wire logic [PC_W-1:0] pc_i,
  // Configuration
  input wire logic stack_fault_reset_enable_i,
  input wire logic powerup_timer_disable_i,
  input wire logic [2:0] osc_mode_i,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Core control
  output logic core_reset_o,
  output logic wake_stall_o,
  output logic pc_load_o,
  output logic [PC_W-1:0] pc_value_o,
  output logic irq_o
);

  // ******************************************************
  // State
  // ******************************************************
  typedef struct packed {
    logic [2:0] sync1;                             // First sync stage
    logic [2:0] sync2;                             // Second sync stage
    rct_seq_e seq;                                 // Sequencer state
    logic [7:0] pwr;                               // Power-control flags
    logic to;                                      // Time-out status
    logic pd;                                      // Power-down status
    logic [IRQ_W-1:0] irq_st;                      // Sticky events
    logic [IRQ_W-1:0] irq_mask;                    // Event mask
    logic irq;                                     // Interrupt level
    logic [7:0] rd;                                // Read data
    logic core_rst;                                // Core held in reset
    logic stall;                                   // Wake time-out running
    logic pc_load;                                 // PC load pulse
    logic [PC_W-1:0] pc_val;                       // PC load value
    logic wake_gie;                                // Wake will vector
    logic vec_pend;                                // Vector after next instr
    logic tmr_load;                                // Timer start pulse
    logic [TMR_W-1:0] tmr_cnt;                     // Timer load value
  } rct_state_s;

  rct_state_s st_ff;
  rct_state_s nxt_st;
  logic tmr_done;                                  // Delay expired pulse
  logic por_s;                                     // Synced power-on
  logic bor_s;                                     // Synced brown-out
  logic pin_n_s;                                   // Synced pin, low active

  assign por_s = st_ff.sync2[0];
  assign bor_s = st_ff.sync2[1];
  assign pin_n_s = st_ff.sync2[2];

  // ******************************************************
  // Helpers
  // ******************************************************
  // Crystal modes need oscillator start-up
  function automatic logic is_xtal(input logic [2:0] m);
    is_xtal = (m == OSC_CRYSTAL_MODE_LOW) || (m == OSC_CRYSTAL_MODE_MID) ||
              (m == OSC_CRYSTAL_MODE_HIGH);
  endfunction : is_xtal

  // Next step of the power-up chain
  function automatic rct_seq_e step_after(input logic from_hold,
                                          input logic [2:0] m,
                                          input logic dis);
    if (from_hold && !dis) begin
      step_after = ST_POWERUP_TIMER;
    end else if (is_xtal(m)) begin
      step_after = ST_OST;
    end else if (from_hold && m == OSC_INTERNAL_OSCILLATOR_MODE) begin
      step_after = ST_SHORT;
    end else begin
      step_after = ST_PIN;
    end
  endfunction : step_after

  // Timer length for a timed step
  function automatic logic [TMR_W-1:0] step_len(input rct_seq_e s);
    case (s)
      ST_POWERUP_TIMER: step_len = TMR_W'(POWERUP_TIMER_CYC);
      ST_OST: step_len = TMR_W'(OST_CYC);
      default: step_len = TMR_W'(INTERNAL_OSCILLATOR_MODE_CYCLES);
    endcase
  endfunction : step_len

  // ******************************************************
  // Delay timer
  // ******************************************************
  rct_delay_tmr #(
    .W(TMR_W)
  ) u_tmr (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .clk_en_i(clk_en_i),
    .load_i(st_ff.tmr_load),
    .count_i(st_ff.tmr_cnt),
    .done_o(tmr_done)
  );

  // ******************************************************
  // Next-state logic
  // ******************************************************
  always_comb begin
    logic [IRQ_W-1:0] ev;
    logic do_rst;
    logic do_wake;
    rct_seq_e nxt_step;
    ev = '0;
    do_rst = 1'b0;
    do_wake = 1'b0;
    nxt_step = ST_PIN;
    nxt_st = st_ff;
    nxt_st.sync1 = {master_clear_pin_n_i, brown_out_reset_i, power_on_req_i};
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.pc_load = 1'b0;
    nxt_st.tmr_load = 1'b0;
    nxt_st.rd = '0;
    // Software writes, hardware below overrides
    if (reg_wr_i && reg_addr_i == OFS_PWR_CTRL) begin
      nxt_st.pwr = reg_wdata_i & POWER_CONTROL_REG_WR_MASK;
    end
    if (reg_wr_i && reg_addr_i == OFS_IRQ_MASK) begin
      nxt_st.irq_mask = reg_wdata_i[IRQ_W-1:0];
    end
    // Stack faults flag in every state unless power-on or brown-out overrides
    if (stack_over_i) begin
      nxt_st.pwr[PCB_STK_OVER] = 1'b1;
      ev[IRB_STACK] = 1'b1;
    end
    if (stack_under_i) begin
      nxt_st.pwr[PCB_STK_UNDER] = 1'b1;
      ev[IRB_STACK] = 1'b1;
    end
    if (por_s) begin
      // Power-on: full flag load
      nxt_st.pwr = POWER_CONTROL_REG_POR_VAL;
      nxt_st.to = 1'b1;
      nxt_st.pd = 1'b1;
      nxt_st.seq = ST_HOLD;
      nxt_st.core_rst = 1'b1;
      nxt_st.stall = 1'b0;
      nxt_st.vec_pend = 1'b0;
    end else if (bor_s) begin
      // Brown-out: power-on bit kept
      nxt_st.pwr = {4'h0, 2'b11, st_ff.pwr[PCB_POR], 1'b0};
      nxt_st.to = 1'b1;
      nxt_st.pd = 1'b1;
      nxt_st.seq = ST_HOLD;
      nxt_st.core_rst = 1'b1;
      nxt_st.stall = 1'b0;
      nxt_st.vec_pend = 1'b0;
      ev[IRB_BOR] = (st_ff.seq != ST_HOLD);
    end else begin
      case (st_ff.seq)
        // Power release starts the chain
        ST_HOLD: begin
          nxt_step = step_after(1'b1, osc_mode_i,
                                powerup_timer_disable_i);
          nxt_st.seq = nxt_step;
          nxt_st.tmr_load = (nxt_step != ST_PIN);
          nxt_st.tmr_cnt = step_len(nxt_step);
        end
        // Power-up timer, pin ignored
        ST_POWERUP_TIMER: begin
          if (tmr_done && !st_ff.tmr_load) begin // Skip stale pulse
            nxt_step = step_after(1'b0, osc_mode_i, 1'b0);
            nxt_st.seq = nxt_step;
            nxt_st.tmr_load = (nxt_step != ST_PIN);
            nxt_st.tmr_cnt = step_len(nxt_step);
          end
        end
        // Final time-outs
        ST_OST, ST_SHORT: begin
          if (tmr_done && !st_ff.tmr_load) begin
            nxt_st.seq = ST_PIN;
          end
        end
        // Release once pin is high
        ST_PIN: begin
          if (pin_n_s) begin
            nxt_st.seq = ST_RUN;
            nxt_st.core_rst = 1'b0;
            nxt_st.pc_load = 1'b1;
            nxt_st.pc_val = PC_RESET_VEC;
            ev[IRB_READY] = 1'b1;
          end
        end
        // Running or asleep
        ST_RUN: begin
          if (!pin_n_s) begin
            nxt_st.pwr[PCB_PIN] = 1'b0;
            ev[IRB_PIN] = 1'b1;
            if (sleep_i) begin
              nxt_st.to = 1'b1;
              nxt_st.pd = 1'b0;
            end
            do_rst = 1'b1;
          end else if (wdt_timeout_i) begin
            ev[IRB_WDT] = 1'b1;
            nxt_st.to = 1'b0;
            if (sleep_i) begin
              nxt_st.pd = 1'b0;
              nxt_st.wake_gie = 1'b0;
              do_wake = 1'b1;
            end else begin
              do_rst = 1'b1;
            end
          end else if (sw_reset_instr_i) begin
            nxt_st.pwr[PCB_SWRST] = 1'b0;
            ev[IRB_SWRST] = 1'b1;
            do_rst = 1'b1;
          end else if ((stack_over_i || stack_under_i) &&
                       stack_fault_reset_enable_i) begin
            do_rst = 1'b1;
          end else if (wake_irq_i && sleep_i) begin
            nxt_st.to = 1'b1;
            nxt_st.pd = 1'b0;
            nxt_st.wake_gie = global_irq_enable_i;
            do_wake = 1'b1;
          end else if (st_ff.vec_pend && instr_done_i) begin
            // Vector after the instruction past sleep
            nxt_st.vec_pend = 1'b0;
            nxt_st.pc_load = 1'b1;
            nxt_st.pc_val = PC_IRQ_VEC;
          end
          if (do_rst) begin
            nxt_st.seq = ST_PIN;
            nxt_st.core_rst = 1'b1;
            nxt_st.vec_pend = 1'b0;
          end else if (do_wake) begin
            if (is_xtal(osc_mode_i) ||
                osc_mode_i == OSC_INTERNAL_OSCILLATOR_MODE) begin
              nxt_st.seq = ST_WAKE;
              nxt_st.stall = 1'b1;
              nxt_st.tmr_load = 1'b1;
              nxt_st.tmr_cnt = is_xtal(osc_mode_i) ? step_len(ST_OST) :
                               step_len(ST_SHORT);
            end else begin
              nxt_st.pc_load = 1'b1;
              nxt_st.pc_val = pc_i + 1'b1;
              nxt_st.vec_pend = nxt_st.wake_gie;
            end
          end
        end
        // Wake time-out, then continue
        ST_WAKE: begin
          if (tmr_done && !st_ff.tmr_load) begin
            nxt_st.seq = ST_RUN;
            nxt_st.stall = 1'b0;
            nxt_st.pc_load = 1'b1;
            nxt_st.pc_val = pc_i + 1'b1;
            nxt_st.vec_pend = st_ff.wake_gie;
          end
        end
        default: begin
          nxt_st.seq = ST_HOLD;
          nxt_st.core_rst = 1'b1;
        end
      endcase
    end
    // Sticky events, set wins over clear
    if (reg_wr_i && reg_addr_i == OFS_IRQ_STAT) begin
      nxt_st.irq_st = st_ff.irq_st & ~reg_wdata_i[IRQ_W-1:0];
    end
    nxt_st.irq_st = nxt_st.irq_st | ev;
    nxt_st.irq = |(nxt_st.irq_st & nxt_st.irq_mask);
    // Read data for the following cycle
    if (reg_rd_i) begin
      case (reg_addr_i)
        OFS_PWR_CTRL: nxt_st.rd = st_ff.pwr & POWER_CONTROL_REG_WR_MASK;
        OFS_CORE_STAT: begin
          nxt_st.rd[STB_TIMEOUT] = st_ff.to;
          nxt_st.rd[STB_POWERDOWN] = st_ff.pd;
        end
        OFS_IRQ_STAT: nxt_st.rd[IRQ_W-1:0] = st_ff.irq_st;
        OFS_IRQ_MASK: nxt_st.rd[IRQ_W-1:0] = st_ff.irq_mask;
        default: nxt_st.rd = '0;
      endcase
    end
  end

  // State register, power-on values at reset
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= '0;
      st_ff.sync1 <= SYNC_RST_VAL;
      st_ff.sync2 <= SYNC_RST_VAL;
      st_ff.seq <= ST_HOLD;
      st_ff.pwr <= POWER_CONTROL_REG_POR_VAL;
      st_ff.to <= 1'b1;
      st_ff.pd <= 1'b1;
      st_ff.core_rst <= 1'b1;
    end else if (clk_en_i) begin
      st_ff <= nxt_st;
    end
  end

  // ******************************************************
  // Outputs
  // ******************************************************
  assign reg_rdata_o = st_ff.rd;
  assign core_reset_o = st_ff.core_rst;
  assign wake_stall_o = st_ff.stall;
  assign pc_load_o = st_ff.pc_load;
  assign pc_value_o = st_ff.pc_val;
  assign irq_o = st_ff.irq;

  // ******************************************************
  // Assertions
  // ******************************************************
  logic quiet_run;                                 // Running, no other cause
  assign quiet_run = clk_en_i && st_ff.seq == ST_RUN && pin_n_s && !por_s &&
                     !bor_s && !wdt_timeout_i;

  sequence SEQ_POWERUP_TIMER_END;
    clk_en_i && st_ff.seq == ST_POWERUP_TIMER && tmr_done && !st_ff.tmr_load &&
    !por_s && !bor_s;
  endsequence

  sequence SEQ_PIN_GO;
    clk_en_i && st_ff.seq == ST_PIN && pin_n_s && !por_s && !bor_s;
  endsequence

  AST_SW_RESET: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    quiet_run && sw_reset_instr_i |=> core_reset_o && !st_ff.pwr[PCB_SWRST])
    else $error("reset instruction not handled");
  AST_STK_RESET: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    quiet_run && !sw_reset_instr_i && stack_over_i &&
    stack_fault_reset_enable_i |=> core_reset_o && st_ff.pwr[PCB_STK_OVER])
    else $error("enabled stack fault did not reset");
  AST_STK_NORESET: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i)
    quiet_run && !sw_reset_instr_i && stack_under_i &&
    !stack_fault_reset_enable_i
    |=> !core_reset_o && st_ff.pwr[PCB_STK_UNDER])
    else $error("disabled stack fault misbehaved");
  AST_STK_HOLD: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    st_ff.pwr[PCB_STK_OVER] && !por_s && !bor_s &&
    !(reg_wr_i && reg_addr_i == OFS_PWR_CTRL) |=> st_ff.pwr[PCB_STK_OVER])
    else $error("stack flag lost");
  AST_POWERUP_TIMER_ORDER: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i)
    SEQ_POWERUP_TIMER_END ##1 clk_en_i[*2] |-> st_ff.seq == ST_OST ||
    st_ff.seq == ST_PIN || st_ff.seq == ST_RUN)
    else $error("power-up chain out of order");
  AST_EC_NOWAIT: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && st_ff.seq == ST_HOLD && !por_s && !bor_s &&
    powerup_timer_disable_i && osc_mode_i == OSC_EXTERNAL_CLOCK_MODE
    |=> st_ff.seq == ST_PIN && !st_ff.tmr_load)
    else $error("time-out applied with external clock");
  AST_PIN_GO: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    SEQ_PIN_GO |=> !core_reset_o && pc_load_o &&
    pc_value_o == PC_RESET_VEC)
    else $error("pin release did not start core");
  AST_PIN_FLAG: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && st_ff.seq == ST_RUN && !pin_n_s && !por_s && !bor_s
    |=> !st_ff.pwr[PCB_PIN] && core_reset_o)
    else $error("pin reset flag not cleared");
  AST_POR_FLAGS: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && por_s |=> st_ff.pwr == POWER_CONTROL_REG_POR_VAL && st_ff.to && st_ff.pd)
    else $error("power-on flags wrong");
  AST_BOR_FLAG: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && bor_s && !por_s |=> !st_ff.pwr[PCB_BOR] && core_reset_o)
    else $error("brown-out flag not cleared");
  AST_RSV_ZERO: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    reg_rdata_o[5:4] == 2'b00 || $past(reg_addr_i) != OFS_PWR_CTRL)
    else $error("unimplemented bits read nonzero");

endmodule : rct_top
`default_nettype wire

// ### dv/rct_core_model.sv
// Purpose: Core model stepping the program counter
// Assumes: One instruction retired per cycle out of reset
// Notes:   Takes the loaded value whenever the block pulses a load
`timescale 1ns/100ps
`default_nettype none
module rct_core_model
  import rct_pkg::*;
(
  // Clock and core reset
  input wire logic core_clk_i,
  input wire logic core_reset_i,
  // Load from the block
  input wire logic pc_load_i,
  input wire logic [PC_W-1:0] pc_value_i,
  // Core state
  output logic [PC_W-1:0] pc_o,
  output logic instr_done_o
);
  // Step, hold in reset or load
  always_ff @(posedge core_clk_i) begin
    instr_done_o <= !core_reset_i;
    if (pc_load_i) begin
      pc_o <= pc_value_i;
    end else if (core_reset_i) begin
      pc_o <= 15'h0000;
    end else begin
      pc_o <= pc_o + 15'h0001;
    end
  end
endmodule : rct_core_model
`default_nettype wire

// ### dv/tb.sv
// Purpose: Register-level bench for the reset-cause block
// Assumes: Short timer counts so start-up takes tens of cycles
// Notes:   Crystal mode first, external clock with timer off at the end
`timescale 1ns/100ps
`default_nettype none
module tb;
  import rct_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, por = 1'b0, bor = 1'b0, pin_n = 1'b1;
  logic swr = 1'b0, sov = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wd = 8'h00, rdata;
  logic cen = 1'b1, sun = 1'b0, wdt = 1'b0, wk = 1'b0, slp = 1'b0;
  logic global_irq_enable = 1'b0, sre = 1'b0, pdis = 1'b0;
  logic [2:0] osc = 3'h0;
  logic [PC_W-1:0] pc, pcv;
  logic crst, stall, pld, irq, done;
  int miscompares = 0, check_count = 0;
  always #5 clk = ~clk;
  rct_top #(.POWERUP_TIMER_CYC(20), .OST_CYC(8)) rct_top_inst (.core_clk_i(clk),
    .rst_n_i(rst_n), .clk_en_i(cen), .power_on_req_i(por),
    .brown_out_reset_i(bor), .master_clear_pin_n_i(pin_n),
    .sw_reset_instr_i(swr), .stack_over_i(sov), .stack_under_i(sun),
    .wdt_timeout_i(wdt), .wake_irq_i(wk), .sleep_i(slp),
    .global_irq_enable_i(global_irq_enable), .instr_done_i(done), .pc_i(pc),
    .stack_fault_reset_enable_i(sre), .powerup_timer_disable_i(pdis),
    .osc_mode_i(osc), .reg_addr_i(addr), .reg_wdata_i(wd),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .core_reset_o(crst), .wake_stall_o(stall), .pc_load_o(pld),
    .pc_value_o(pcv), .irq_o(irq));
  rct_core_model rct_core_model_inst (.core_clk_i(clk), .core_reset_i(crst),
    .pc_load_i(pld), .pc_value_i(pcv), .pc_o(pc), .instr_done_o(done));
  // Compare one value
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task wrr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk) begin addr <= a; wd <= d; wr <= 1'b1; end
    @(posedge clk) wr <= 1'b0;
  endtask : wrr
  task rdr(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk) begin addr <= a; rd <= 1'b1; end
    @(posedge clk) rd <= 1'b0;
    #1 chk(rdata, e);
  endtask : rdr
  // Wait for the core to run, bounded
  task wait_run;
    repeat (5) @(posedge clk);
    #1;
    for (int i = 0; i < 500 && crst !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    chk(crst, 1'b0);
  endtask : wait_run
  task results;
    $display("checks=%0d miscompares=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results
  initial begin
    #100us;
    miscompares++;
    results();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    wait_run();
    chk(pcv, 15'h0000);
    rdr(3'h0, 8'h0C);
    rdr(3'h1, 8'h18);
    wrr(3'h0, 8'hFF);
    rdr(3'h0, 8'hCF);
    @(posedge clk) swr <= 1'b1;
    @(posedge clk) swr <= 1'b0;
    wait_run();
    rdr(3'h0, 8'hCB);
    wrr(3'h0, 8'h0F);
    wrr(3'h3, 8'h02);
    @(posedge clk) begin sov <= 1'b1; sun <= 1'b1; end
    @(posedge clk) begin sov <= 1'b0; sun <= 1'b0; end
    rdr(3'h0, 8'hCF);
    chk(crst, 1'b0);
    chk(irq, 1'b1);
    wrr(3'h2, 8'h3F);
    @(posedge clk) #1 chk(irq, 1'b0);
    @(posedge clk) begin bor <= 1'b1; pin_n <= 1'b0; end
    repeat (5) @(posedge clk);
    bor <= 1'b0;
    repeat (60) @(posedge clk);
    #1 chk(crst, 1'b1);
    @(posedge clk) pin_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk(crst, 1'b0);
    rdr(3'h0, 8'h0E);
    @(posedge clk) pin_n <= 1'b0;
    repeat (5) @(posedge clk);
    pin_n <= 1'b1;
    wait_run();
    rdr(3'h0, 8'h06);
    // Reset instruction while the clock is disabled is not taken
    @(posedge clk) begin cen <= 1'b0; swr <= 1'b1; end
    @(posedge clk) begin cen <= 1'b1; swr <= 1'b0; end
    rdr(3'h0, 8'h06);
    // Watchdog reset while awake
    @(posedge clk) wdt <= 1'b1;
    @(posedge clk) wdt <= 1'b0;
    #1 chk(crst, 1'b1);
    wait_run();
    rdr(3'h1, 8'h08);
    // Interrupt wake with global enable: stall, PC+1, then vector
    @(posedge clk) begin slp <= 1'b1; global_irq_enable <= 1'b1; end
    @(posedge clk) wk <= 1'b1;
    @(posedge clk) begin wk <= 1'b0; slp <= 1'b0; global_irq_enable <= 1'b0; end
    #1 chk(stall, 1'b1);
    for (int i = 0; i < 50 && pld !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk(pld, 1'b1);
    chk(pcv, pc);
    chk(stall, 1'b0);
    @(posedge clk) #1 chk(pcv, 15'h0004);
    chk(pld, 1'b1);
    rdr(3'h1, 8'h10);
    // Stack fault with reset enabled
    @(posedge clk) begin sre <= 1'b1; sov <= 1'b1; end
    @(posedge clk) sov <= 1'b0;
    #1 chk(crst, 1'b1);
    wait_run();
    chk(pcv, 15'h0000);
    rdr(3'h0, 8'h86);
    // External clock, timer disabled: release with no time-out
    @(posedge clk) begin osc <= 3'h4; pdis <= 1'b1; bor <= 1'b1; end
    repeat (4) @(posedge clk);
    bor <= 1'b0;
    repeat (5) @(posedge clk);
    #1 chk(crst, 1'b0);
    // Power-on request reloads every flag
    @(posedge clk) por <= 1'b1;
    repeat (4) @(posedge clk);
    por <= 1'b0;
    wait_run();
    rdr(3'h0, 8'h0C);
    rdr(3'h1, 8'h18);
    results();
  end
endmodule : tb
`default_nettype wire
